/* rtl/dpgc_pkg.sv */
// Package: register map, field layout and lock-mode codes of the detector gain block
package dpgc_pkg;
  // ----------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------
  localparam logic [7:0] DPGC_MAIN_IDX = 8'h6D;
  localparam logic [7:0] DPGC_SEC_IDX = 8'h6C;
  localparam logic [9:0] DPGC_MAIN_ADDR = {DPGC_MAIN_IDX, 2'b00};
  localparam logic [9:0] DPGC_SEC_ADDR = {DPGC_SEC_IDX, 2'b00};
  localparam int DPGC_ADDR_W = 10;
  localparam int DPGC_DATA_W = 32;

  // ----------------------------------------
  // Field layout and reset values
  // ----------------------------------------
  localparam int DPGC_EN_BIT = 7;
  localparam int DPGC_ALOG_MSB = 6;
  localparam int DPGC_ALOG_LSB = 4;
  localparam int DPGC_DIG_MSB = 2;
  localparam int DPGC_DIG_LSB = 0;
  localparam logic [7:0] DPGC_WMASK = 8'hF7;
  localparam logic [7:0] DPGC_MAIN_RST = 8'hC2;
  localparam logic [7:0] DPGC_SEC_RST = 8'hC2;
  localparam logic [2:0] DPGC_GAIN_OFF = 3'h0;

  // ----------------------------------------
  // Locking modes reported by the loop
  // ----------------------------------------
  typedef logic [1:0] dpgc_mode_t;
  localparam dpgc_mode_t DPGC_MODE_DIGITAL = 2'h0;
  localparam dpgc_mode_t DPGC_MODE_ANALOG = 2'h1;
  localparam dpgc_mode_t DPGC_MODE_ANALOG_8K = 2'h2;
endpackage : dpgc_pkg

/* rtl/dpgc_regs.sv */
// Detector gain configuration registers for the secondary and main timing loops
`timescale 1ns/10ps
module dpgc_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dpgc_pkg::DPGC_ADDR_W-1:0] paddr,
  input wire logic [dpgc_pkg::DPGC_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [dpgc_pkg::DPGC_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire dpgc_pkg::dpgc_mode_t main_lock_mode,
  input wire logic [2:0] main_det2_gain_8k,
  input wire dpgc_pkg::dpgc_mode_t secondary_lock_mode,
  input wire logic [2:0] secondary_det2_gain_8k,
  output logic main_det2_en,
  output logic [2:0] main_det2_gain,
  output logic secondary_det2_en,
  output logic [2:0] secondary_det2_gain
);
  import dpgc_pkg::*;

  // ----------------------------------------
  // Gain selection
  // ----------------------------------------
  // The 8 kHz gain lives in the neighbouring damping register, so it arrives as a port.
  function automatic logic [3:0] dpgc_pick(input logic [7:0] cfg, input dpgc_mode_t mode,
                                           input logic [2:0] gain_8k);
    logic [3:0] res;
    res = {1'b0, DPGC_GAIN_OFF};
    if (cfg[DPGC_EN_BIT]) begin
      case (mode)
        DPGC_MODE_DIGITAL: res = {1'b1, cfg[DPGC_DIG_MSB:DPGC_DIG_LSB]};
        DPGC_MODE_ANALOG: res = {1'b1, cfg[DPGC_ALOG_MSB:DPGC_ALOG_LSB]};
        DPGC_MODE_ANALOG_8K: res = {1'b1, gain_8k};
        default: res = {1'b1, cfg[DPGC_DIG_MSB:DPGC_DIG_LSB]};
      endcase
    end
    return res;
  endfunction : dpgc_pick

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic hit_main;
  logic hit_sec;
  logic mapped;
  logic setup;
  logic access;

  always_comb begin
    hit_main = (paddr == DPGC_MAIN_ADDR);
    hit_sec = (paddr == DPGC_SEC_ADDR);
    mapped = hit_main | hit_sec;
    setup = psel & ~penable;
    access = psel & penable;
    pready = 1'b1;
    pslverr = access & ~mapped;
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [7:0] main_cfg;
  logic [7:0] sec_cfg;
  logic [7:0] next_main_cfg;
  logic [7:0] next_sec_cfg;
  logic [DPGC_DATA_W-1:0] next_prdata;

  always_comb begin
    next_main_cfg = main_cfg;
    next_sec_cfg = sec_cfg;
    // Bit 3 is masked so it can never be stored
    if (access && pwrite && pstrb[0] && hit_main) begin
      next_main_cfg = pwdata[7:0] & DPGC_WMASK;
    end
    if (access && pwrite && pstrb[0] && hit_sec) begin
      next_sec_cfg = pwdata[7:0] & DPGC_WMASK;
    end
    // Read data is captured in the setup cycle so it leaves a flip-flop in the access cycle
    next_prdata = prdata;
    if (setup) begin
      next_prdata = '0;
      if (hit_main) begin
        next_prdata = {24'h000000, main_cfg & DPGC_WMASK};
      end else if (hit_sec) begin
        next_prdata = {24'h000000, sec_cfg & DPGC_WMASK};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_cfg <= DPGC_MAIN_RST;
      sec_cfg <= DPGC_SEC_RST;
      prdata <= '0;
    end else begin
      main_cfg <= next_main_cfg;
      sec_cfg <= next_sec_cfg;
      prdata <= next_prdata;
    end
  end

  // ----------------------------------------
  // Detector controls
  // ----------------------------------------
  logic [3:0] next_main_sel;
  logic [3:0] next_sec_sel;

  always_comb begin
    next_main_sel = dpgc_pick(main_cfg, main_lock_mode, main_det2_gain_8k);
    next_sec_sel = dpgc_pick(sec_cfg, secondary_lock_mode, secondary_det2_gain_8k);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_det2_en <= 1'b0;
      main_det2_gain <= DPGC_GAIN_OFF;
      secondary_det2_en <= 1'b0;
      secondary_det2_gain <= DPGC_GAIN_OFF;
    end else begin
      main_det2_en <= next_main_sel[3];
      main_det2_gain <= next_main_sel[2:0];
      secondary_det2_en <= next_sec_sel[3];
      secondary_det2_gain <= next_sec_sel[2:0];
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // Attempts at the edge that releases reset would still see reset outputs, so they start later
  sequence s_main_on_digital;
    $past(presetn) && main_cfg[DPGC_EN_BIT] && main_lock_mode == DPGC_MODE_DIGITAL;
  endsequence

  sequence s_sec_on_analog;
    $past(presetn) && sec_cfg[DPGC_EN_BIT] && secondary_lock_mode == DPGC_MODE_ANALOG;
  endsequence

  AST_SEC_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    !sec_cfg[DPGC_EN_BIT] |=> !secondary_det2_en && secondary_det2_gain == 3'h0)
    else $error("secondary detector active while disabled");

  AST_SEC_ON: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) && sec_cfg[DPGC_EN_BIT] |=> secondary_det2_en)
    else $error("secondary detector not enabled");

  AST_MAIN_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    !main_cfg[DPGC_EN_BIT] |=> !main_det2_en && main_det2_gain == 3'h0)
    else $error("main detector active while disabled");

  AST_MAIN_ON_8K: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) && main_cfg[DPGC_EN_BIT] && main_lock_mode == DPGC_MODE_ANALOG_8K
    |=> main_det2_en && main_det2_gain == $past(main_det2_gain_8k))
    else $error("main detector 8 kHz gain wrong");

  AST_ANALOG_GAIN: assert property (@(posedge pclk) disable iff (!presetn)
    s_sec_on_analog |=> secondary_det2_gain == $past(sec_cfg[DPGC_ALOG_MSB:DPGC_ALOG_LSB]))
    else $error("analog gain not applied");

  AST_DIGITAL_GAIN: assert property (@(posedge pclk) disable iff (!presetn)
    s_main_on_digital |=> main_det2_gain == $past(main_cfg[DPGC_DIG_MSB:DPGC_DIG_LSB]))
    else $error("digital gain not applied");

  AST_BIT3_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pwrite |-> prdata[3] == 1'b0 && prdata[31:8] == 24'h000000)
    else $error("unused read bits not zero");

  AST_WRITE_TAKES: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pwrite && pstrb[0] && hit_main
    |=> main_cfg == ($past(pwdata[7:0]) & DPGC_WMASK))
    else $error("main register write lost");

  AST_MAIN_ON: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) && main_cfg[DPGC_EN_BIT] |=> main_det2_en)
    else $error("main detector not enabled");

  AST_SEC_8K: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) && sec_cfg[DPGC_EN_BIT] && secondary_lock_mode == DPGC_MODE_ANALOG_8K
    |=> secondary_det2_en && secondary_det2_gain == $past(secondary_det2_gain_8k))
    else $error("secondary detector 8 kHz gain wrong");

  AST_MAIN_ANALOG: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) && main_cfg[DPGC_EN_BIT] && main_lock_mode == DPGC_MODE_ANALOG
    |=> main_det2_gain == $past(main_cfg[DPGC_ALOG_MSB:DPGC_ALOG_LSB]))
    else $error("main analog gain not applied");

  AST_SEC_DIGITAL: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) && sec_cfg[DPGC_EN_BIT] && secondary_lock_mode == DPGC_MODE_DIGITAL
    |=> secondary_det2_gain == $past(sec_cfg[DPGC_DIG_MSB:DPGC_DIG_LSB]))
    else $error("secondary digital gain not applied");

  // The spare mode code falls back to the digital field, so a stray code still gives a sane gain
  AST_MAIN_SPARE_MODE: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) && main_cfg[DPGC_EN_BIT] && main_lock_mode != DPGC_MODE_DIGITAL
    && main_lock_mode != DPGC_MODE_ANALOG && main_lock_mode != DPGC_MODE_ANALOG_8K
    |=> main_det2_gain == $past(main_cfg[DPGC_DIG_MSB:DPGC_DIG_LSB]))
    else $error("spare mode gain not digital");

  AST_SEC_WRITE_TAKES: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pwrite && pstrb[0] && hit_sec
    |=> sec_cfg == ($past(pwdata[7:0]) & DPGC_WMASK))
    else $error("secondary register write lost");

  AST_STRB_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pwrite && !pstrb[0]
    |=> main_cfg == $past(main_cfg) && sec_cfg == $past(sec_cfg))
    else $error("write without low strobe changed a register");

  AST_BIT3_STORED: assert property (@(posedge pclk) disable iff (!presetn)
    (main_cfg & ~DPGC_WMASK) == 8'h00 && (sec_cfg & ~DPGC_WMASK) == 8'h00)
    else $error("unused bit stored");

  sequence s_main_read;
    psel && !penable && !pwrite && hit_main ##1 psel && penable;
  endsequence

  AST_READ_MAIN: assert property (@(posedge pclk) disable iff (!presetn)
    s_main_read |-> prdata == {24'h000000, $past(main_cfg)})
    else $error("main register read data wrong");
endmodule : dpgc_regs

/* test/testbench.sv */
// Self-checking bench for the detector gain configuration registers
`timescale 1ns/10ps
module testbench;
  import dpgc_pkg::*;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [9:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  dpgc_mode_t main_lock_mode = '0;
  dpgc_mode_t secondary_lock_mode = '0;
  logic [2:0] main_det2_gain_8k = '0;
  logic [2:0] secondary_det2_gain_8k = '0;
  logic main_det2_en;
  logic [2:0] main_det2_gain;
  logic secondary_det2_en;
  logic [2:0] secondary_det2_gain;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [31:0] seed = 32'hFE6C;
  logic [32:0] expq[$];
  logic [7:0] detq[$];
  logic [7:0] dexp;
  logic [7:0] cfg[2];

  dpgc_regs u_dpgc_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .main_lock_mode(main_lock_mode),
    .main_det2_gain_8k(main_det2_gain_8k), .secondary_lock_mode(secondary_lock_mode),
    .secondary_det2_gain_8k(secondary_det2_gain_8k), .main_det2_en(main_det2_en),
    .main_det2_gain(main_det2_gain), .secondary_det2_en(secondary_det2_en),
    .secondary_det2_gain(secondary_det2_gain));

  initial begin
    forever #20 pclk = ~pclk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [3:0] sel(logic [7:0] c, logic [1:0] m, logic [2:0] g8);
    if (!c[7]) return 4'h0;
    return {1'b1, m == 2'h1 ? c[6:4] : m == 2'h2 ? g8 : c[2:0]};
  endfunction : sel

  task automatic chk(string name, logic [32:0] seen, logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report

  // ----------------------------------------
  // APB master; one idle edge between transfers keeps each signal single-driven per step
  // ----------------------------------------
  task automatic apb(logic wr, logic [9:0] a, logic [31:0] d, logic [32:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    expq.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic det(logic [1:0] m);
    logic [5:0] g;
    @(posedge pclk);
    g = 6'(rnd());
    main_lock_mode <= m;
    secondary_lock_mode <= m;
    main_det2_gain_8k <= g[2:0];
    secondary_det2_gain_8k <= g[5:3];
    @(posedge pclk);
    detq.push_back({sel(cfg[1], m, g[2:0]), sel(cfg[0], m, g[5:3])});
  endtask : det

  // Read results are judged here, in the access cycle, against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      if (expq.size() == 0) chk("bus note", 33'h0, 33'h1);
      else if (pwrite) chk("write error", {pslverr, 32'h0}, expq.pop_front());
      else chk("read data", {pslverr, prdata}, expq.pop_front());
    end
  end

  // Detector outputs settle one edge after their cause; they are judged at the falling edge
  always @(negedge pclk) begin
    if (detq.size() > 0) begin
      dexp = detq.pop_front();
      chk("main det2", {29'h0, main_det2_en, main_det2_gain}, {29'h0, dexp[7:4]});
      chk("sec det2", {29'h0, secondary_det2_en, secondary_det2_gain},
        {29'h0, dexp[3:0]});
    end
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      final_report;
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    cfg[0] = DPGC_SEC_RST;
    cfg[1] = DPGC_MAIN_RST;
    apb(1'b0, DPGC_MAIN_ADDR, '0, {25'h0, DPGC_MAIN_RST});
    apb(1'b0, DPGC_SEC_ADDR, '0, {25'h0, DPGC_SEC_RST});
    apb(1'b0, 10'h3FC, '0, {1'b1, 32'h0});
    det(2'h1);
    for (int i = 0; i < 16; i++) begin
      logic [31:0] d;
      logic [9:0] a;
      d = rnd();
      // The first pass on each loop runs disabled so the off state is seen early
      if (i < 2) d[7] = 1'b0;
      a = (i % 2) ? DPGC_MAIN_ADDR : DPGC_SEC_ADDR;
      cfg[i % 2] = d[7:0] & DPGC_WMASK;
      apb(1'b1, a, d, '0);
      apb(1'b0, a, '0, {25'h0, cfg[i % 2]});
      det(2'(i));
    end
    // Neither a write without the low byte strobe nor a write to a hole may touch a register
    pstrb <= 4'hE;
    apb(1'b1, DPGC_MAIN_ADDR, {24'h000000, ~cfg[1]}, '0);
    pstrb <= 4'hF;
    apb(1'b1, 10'h3FC, {24'h000000, ~cfg[0]}, {1'b1, 32'h0});
    apb(1'b0, DPGC_MAIN_ADDR, '0, {25'h0, cfg[1]});
    apb(1'b0, DPGC_SEC_ADDR, '0, {25'h0, cfg[0]});
    // A reset in mid-run must bring back the power-on values
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    cfg[0] = DPGC_SEC_RST;
    cfg[1] = DPGC_MAIN_RST;
    apb(1'b0, DPGC_MAIN_ADDR, '0, {25'h0, DPGC_MAIN_RST});
    apb(1'b0, DPGC_SEC_ADDR, '0, {25'h0, DPGC_SEC_RST});
    det(2'h2);
    final_report;
  end
endmodule : testbench
